// ### hdl/ctad_datapath.v
// Transfer and arithmetic execution datapath with register file and flags
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
// ==========================================================================
// Overview of operation
// - Transfer copies byte/word register-register, register-memory, or immediate.
// - Word transfers use direct, indirect, disp16, abs16, imm16, predec, postinc.
// - Short 8-bit absolute form accepted only for byte transfers.
// - Stack pull reads word at stack pointer, then advances pointer.
// - Stack store decrements pointer, then writes the word there.
// - Add and subtract use two registers; add also takes an immediate.
// - Plain subtract has no immediate form.
// - Word add and subtract only between two registers.
// - Carry add and borrow subtract are byte only, register or immediate.
// - Step up and step down change a register by exactly one.
// - Small-step add and subtract change a register by one or two.
// - Decimal fix corrects a result to packed BCD using the carry flag.
// - Unsigned product: two bytes give a 16-bit result.
// - Unsigned quotient: 16 by 8 gives 8-bit quotient and remainder.
// - Compare subtracts without storing, updating flags only.
// - Word compare only between registers; byte compare may use immediate.
// - Twos complement op replaces a byte register with zero minus it.
// - Flag register holds N, Z, V, C, read by carry-using ops.
// - Post-increment advances by one for bytes and two for words.
// - Short absolute address gets all-ones upper byte.
// - Word access to odd address clears the lowest address bit.
// ==========================================================================
`include "ctad_consts.vh"

module ctad_datapath (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire OP_VALID,
  output wire OP_READY,
  input wire [4:0] OP_CODE,
  input wire OP_WORD,
  input wire [2:0] OP_MODE,
  input wire OP_STORE,
  input wire [3:0] OP_RD,
  input wire [3:0] OP_RS,
  input wire [15:0] OP_IMM,
  output reg OP_DONE,
  output reg OP_ERR,
  output reg [15:0] MEM_ADDR,
  output reg MEM_WORD,
  output reg MEM_RD,
  output reg MEM_WR,
  output reg [15:0] MEM_WDATA,
  input wire [15:0] MEM_RDATA,
  input wire [3:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [15:0] REG_RDATA
);

  // ========================================================================
  // State and storage
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ACC = 2'h1;
  localparam [1:0] ST_LOAD = 2'h2;

  reg [1:0] state_q;
  reg [15:0] gr_q [0:7];
  reg [3:0] flags_q;
  reg err_q;
  reg [3:0] ld_reg_q;
  reg ld_word_q;
  integer i;
  // Byte register index: bit 3 picks the low half, bits 2:0 the word register
  function [7:0] pick_byte;
    input [15:0] w;
    input lo;
    begin
      pick_byte = lo ? w[7:0] : w[15:8];
    end
  endfunction

  function [15:0] put_byte;
    input [15:0] w;
    input lo;
    input [7:0] b;
    begin
      put_byte = lo ? {w[15:8], b} : {b, w[7:0]};
    end
  endfunction

  // ========================================================================
  // Operand fetch
  wire accept = OP_VALID && (state_q == ST_IDLE);
  assign OP_READY = (state_q == ST_IDLE);
  wire is_pull = (OP_CODE == `CTAD_OP_PULL);
  wire is_push = (OP_CODE == `CTAD_OP_STORE_STK);
  wire [15:0] rd_w = gr_q[OP_RD[2:0]];
  wire [15:0] rs_w = gr_q[OP_RS[2:0]];
  wire [7:0] rd_b = pick_byte(rd_w, OP_RD[3]);
  wire [7:0] rs_b = pick_byte(rs_w, OP_RS[3]);
  wire use_imm = (OP_MODE == `CTAD_AM_IMM);
  wire [15:0] src_w = use_imm ? OP_IMM : rs_w;
  wire [7:0] src_b = use_imm ? OP_IMM[7:0] : rs_b;
  wire cflag = flags_q[`CTAD_FLAG_C];
  // Stack forms always address through the stack register
  wire [2:0] ptr_idx = (is_pull || is_push) ? `CTAD_STACK_REG : OP_RS[2:0];
  wire [15:0] ptr_w = gr_q[ptr_idx];

  // Effective size: several operations have a fixed width
  reg eff_word;
  always @* begin
    case (OP_CODE)
      `CTAD_OP_PULL, `CTAD_OP_STORE_STK, `CTAD_OP_SMALL_UP,
      `CTAD_OP_SMALL_DOWN, `CTAD_OP_PRODUCT, `CTAD_OP_QUOTIENT: eff_word = 1'b1;
      `CTAD_OP_SUM_CARRY, `CTAD_OP_MINUS_BORROW, `CTAD_OP_STEP_UP,
      `CTAD_OP_STEP_DOWN, `CTAD_OP_FIX_SUM, `CTAD_OP_FIX_MINUS,
      `CTAD_OP_TWOS: eff_word = 1'b0;
      default: eff_word = OP_WORD;
    endcase
  end

  // ========================================================================
  // Shared adder operand selection
  reg [15:0] add_a;
  reg [15:0] add_b;
  reg add_sub;
  reg add_cin;
  always @* begin
    add_a = eff_word ? rd_w : {8'h00, rd_b};
    add_b = eff_word ? src_w : {8'h00, src_b};
    add_sub = 1'b0;
    add_cin = 1'b0;
    case (OP_CODE)
      `CTAD_OP_SUB, `CTAD_OP_COMPARE: add_sub = 1'b1;
      `CTAD_OP_SUM_CARRY: add_cin = cflag;
      `CTAD_OP_MINUS_BORROW: begin
        add_sub = 1'b1;
        add_cin = cflag;
      end
      `CTAD_OP_STEP_UP: add_b = 16'h0001;
      `CTAD_OP_STEP_DOWN: begin
        add_b = 16'h0001;
        add_sub = 1'b1;
      end
      `CTAD_OP_SMALL_UP: add_b = OP_IMM[1] ? 16'h0002 : 16'h0001;
      `CTAD_OP_SMALL_DOWN: begin
        add_b = OP_IMM[1] ? 16'h0002 : 16'h0001;
        add_sub = 1'b1;
      end
      `CTAD_OP_TWOS: begin
        add_a = 16'h0000;
        add_b = {8'h00, rd_b};
        add_sub = 1'b1;
      end
      default: add_sub = 1'b0;
    endcase
  end

  // A 17-bit adder serves words and a separate 9-bit adder bytes; the byte carry is taken from bit 8
  wire [16:0] sum_w = add_sub ? ({1'b0, add_a} - {1'b0, add_b} - {16'h0000, add_cin})
                              : ({1'b0, add_a} + {1'b0, add_b} + {16'h0000, add_cin});
  wire [8:0] sum_b = add_sub ? ({1'b0, add_a[7:0]} - {1'b0, add_b[7:0]} - {8'h00, add_cin})
                             : ({1'b0, add_a[7:0]} + {1'b0, add_b[7:0]} + {8'h00, add_cin});
  wire sa = eff_word ? add_a[15] : add_a[7];
  wire sb = eff_word ? add_b[15] : add_b[7];
  wire [15:0] ar = eff_word ? sum_w[15:0] : {8'h00, sum_b[7:0]};
  wire sr = eff_word ? ar[15] : ar[7];
  wire ar_zero = eff_word ? (ar == 16'h0000) : (ar[7:0] == 8'h00);
  wire ar_c = eff_word ? sum_w[16] : sum_b[8];
  wire ar_v = add_sub ? ((sa != sb) && (sr != sa)) : ((sa == sb) && (sr != sa));

  // ========================================================================
  // Decimal fix, product and quotient
  wire dfix_lo = (rd_b[3:0] > `CTAD_NIBBLE_MAX);
  wire dfix_hi = cflag || (rd_b > `CTAD_BCD_MAX);
  wire [7:0] dfix_amt = (dfix_hi ? `CTAD_BCD_HI_FIX : 8'h00)
                        | (dfix_lo ? `CTAD_BCD_LO_FIX : 8'h00);
  wire [7:0] dfix_sum = rd_b + dfix_amt;
  wire [7:0] dfix_minus = rd_b - dfix_amt;
  wire [15:0] prod = {8'h00, rd_w[7:0]} * {8'h00, rs_b};
  wire div_zero = (rs_b == 8'h00);
  // Divisor of zero is forced to one here only to keep the divider defined
  wire [15:0] div_den = {8'h00, div_zero ? 8'h01 : rs_b};
  wire [15:0] quo = rd_w / div_den;
  wire [15:0] rem = rd_w % div_den;

  // ========================================================================
  // Address generation for memory transfers
  wire step_two = eff_word;
  wire [15:0] step = step_two ? 16'h0002 : 16'h0001;
  reg [15:0] ea_raw;
  always @* begin
    case (OP_MODE)
      `CTAD_AM_DISP: ea_raw = ptr_w + OP_IMM;
      `CTAD_AM_ABS16: ea_raw = OP_IMM;
      `CTAD_AM_ABS8: ea_raw = {`CTAD_PAGE_HI, OP_IMM[7:0]};
      `CTAD_AM_PREDEC: ea_raw = ptr_w - step;
      default: ea_raw = ptr_w;
    endcase
  end
  wire [15:0] ea = eff_word ? {ea_raw[15:1], 1'b0} : ea_raw;

  // ========================================================================
  // Decode: legality, memory access and register/flag results
  reg legal;
  reg is_mem;
  reg mem_store;
  reg wb_en;
  reg [15:0] wb_val;
  reg [3:0] fl_new;
  reg [2:0] eff_mode;
  always @* begin
    legal = 1'b1;
    is_mem = 1'b0;
    mem_store = 1'b0;
    wb_en = 1'b0;
    wb_val = rd_w;
    fl_new = flags_q;
    eff_mode = OP_MODE;
    if (is_pull)
      eff_mode = `CTAD_AM_POSTINC;
    if (is_push)
      eff_mode = `CTAD_AM_PREDEC;
    case (OP_CODE)
      `CTAD_OP_TRANSFER, `CTAD_OP_PULL, `CTAD_OP_STORE_STK: begin
        mem_store = is_push || (OP_STORE && !is_pull);
        if (eff_mode == `CTAD_AM_ABS8 && eff_word)
          legal = 1'b0;
        if (eff_mode == `CTAD_AM_IMM && mem_store)
          legal = 1'b0;
        // Post-increment only loads, pre-decrement only stores
        if (eff_mode == `CTAD_AM_POSTINC && mem_store)
          legal = 1'b0;
        if (eff_mode == `CTAD_AM_PREDEC && !mem_store)
          legal = 1'b0;
        if (eff_mode == `CTAD_AM_REG || eff_mode == `CTAD_AM_IMM) begin
          wb_en = 1'b1;
          wb_val = eff_word ? src_w : put_byte(rd_w, OP_RD[3], src_b);
          fl_new[`CTAD_FLAG_N] = eff_word ? src_w[15] : src_b[7];
          fl_new[`CTAD_FLAG_Z] = eff_word ? (src_w == 16'h0000) : (src_b == 8'h00);
          fl_new[`CTAD_FLAG_V] = 1'b0;
        end else begin
          is_mem = 1'b1;
          if (mem_store) begin
            fl_new[`CTAD_FLAG_N] = eff_word ? rd_w[15] : rd_b[7];
            fl_new[`CTAD_FLAG_Z] = eff_word ? (rd_w == 16'h0000) : (rd_b == 8'h00);
            fl_new[`CTAD_FLAG_V] = 1'b0;
          end
        end
      end
      `CTAD_OP_ADD, `CTAD_OP_SUB, `CTAD_OP_SUM_CARRY, `CTAD_OP_MINUS_BORROW,
      `CTAD_OP_COMPARE, `CTAD_OP_STEP_UP, `CTAD_OP_STEP_DOWN, `CTAD_OP_TWOS: begin
        if (OP_MODE != `CTAD_AM_REG && OP_MODE != `CTAD_AM_IMM)
          legal = 1'b0;
        if (OP_CODE == `CTAD_OP_SUB && use_imm)
          legal = 1'b0;
        if ((OP_CODE == `CTAD_OP_ADD || OP_CODE == `CTAD_OP_SUB) && OP_WORD && use_imm)
          legal = 1'b0;
        if ((OP_CODE == `CTAD_OP_SUM_CARRY || OP_CODE == `CTAD_OP_MINUS_BORROW) && OP_WORD)
          legal = 1'b0;
        if (OP_CODE == `CTAD_OP_COMPARE && OP_WORD && use_imm)
          legal = 1'b0;
        wb_en = (OP_CODE != `CTAD_OP_COMPARE);
        wb_val = eff_word ? ar : put_byte(rd_w, OP_RD[3], ar[7:0]);
        fl_new[`CTAD_FLAG_N] = sr;
        fl_new[`CTAD_FLAG_Z] = ar_zero;
        fl_new[`CTAD_FLAG_V] = ar_v;
        // Single steps leave carry alone so loop counters keep it
        if (OP_CODE != `CTAD_OP_STEP_UP && OP_CODE != `CTAD_OP_STEP_DOWN)
          fl_new[`CTAD_FLAG_C] = ar_c;
      end
      `CTAD_OP_SMALL_UP, `CTAD_OP_SMALL_DOWN: begin
        wb_en = 1'b1;
        wb_val = ar;
      end
      `CTAD_OP_FIX_SUM, `CTAD_OP_FIX_MINUS: begin
        wb_en = 1'b1;
        wb_val = put_byte(rd_w, OP_RD[3],
                          (OP_CODE == `CTAD_OP_FIX_SUM) ? dfix_sum : dfix_minus);
        fl_new[`CTAD_FLAG_N] = wb_val[OP_RD[3] ? 7 : 15];
        fl_new[`CTAD_FLAG_Z] = (pick_byte(wb_val, OP_RD[3]) == 8'h00);
        fl_new[`CTAD_FLAG_C] = dfix_hi;
      end
      `CTAD_OP_PRODUCT: begin
        wb_en = 1'b1;
        wb_val = prod;
      end
      `CTAD_OP_QUOTIENT: begin
        // A zero divisor is refused and leaves the register untouched
        legal = !div_zero;
        wb_en = 1'b1;
        wb_val = {rem[7:0], quo[7:0]};
        fl_new[`CTAD_FLAG_N] = rs_b[7];
        fl_new[`CTAD_FLAG_Z] = 1'b0;
      end
      default: legal = 1'b0;
    endcase
  end

  // ========================================================================
  // Sequencer, memory strobes, register file and flags
  wire [15:0] ld_val = ld_word_q ? MEM_RDATA
                                 : put_byte(gr_q[ld_reg_q[2:0]], ld_reg_q[3], MEM_RDATA[7:0]);
  wire sw_gr_wr = REG_WR && (REG_ADDR[3] == 1'b0) && (state_q == ST_IDLE) && !accept;
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_q <= ST_IDLE;
      flags_q <= `CTAD_FLAG_RESET;
      err_q <= 1'b0;
      ld_reg_q <= 4'h0;
      ld_word_q <= 1'b0;
      OP_DONE <= 1'b0;
      OP_ERR <= 1'b0;
      MEM_ADDR <= 16'h0000;
      MEM_WORD <= 1'b0;
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      MEM_WDATA <= 16'h0000;
      for (i = 0; i < 8; i = i + 1)
        gr_q[i] <= 16'h0000;
    end else begin
      OP_DONE <= 1'b0;
      OP_ERR <= 1'b0;
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      // Software writes only land while no operation owns the file
      if (sw_gr_wr)
        gr_q[REG_ADDR[2:0]] <= REG_WDATA;
      if (REG_WR && REG_ADDR == `CTAD_REG_FLAGS && state_q == ST_IDLE && !accept)
        flags_q <= REG_WDATA[3:0];
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            err_q <= !legal;
            if (!legal) begin
              OP_DONE <= 1'b1;
              OP_ERR <= 1'b1;
            end else if (is_mem) begin
              MEM_ADDR <= ea;
              MEM_WORD <= eff_word;
              MEM_RD <= !mem_store;
              MEM_WR <= mem_store;
              MEM_WDATA <= eff_word ? rd_w : {8'h00, rd_b};
              flags_q <= fl_new;
              ld_reg_q <= OP_RD;
              ld_word_q <= eff_word;
              if (eff_mode == `CTAD_AM_PREDEC)
                gr_q[ptr_idx] <= ptr_w - step;
              if (eff_mode == `CTAD_AM_POSTINC)
                gr_q[ptr_idx] <= ptr_w + step;
              state_q <= ST_ACC;
            end else begin
              if (wb_en)
                gr_q[OP_RD[2:0]] <= wb_val;
              flags_q <= fl_new;
              OP_DONE <= 1'b1;
            end
          end
        end
        ST_ACC: begin
          if (MEM_WR) begin
            OP_DONE <= 1'b1;
            state_q <= ST_IDLE;
          end else begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // Loaded data wins over a pointer update of the same register
          gr_q[ld_reg_q[2:0]] <= ld_val;
          flags_q[`CTAD_FLAG_N] <= ld_word_q ? MEM_RDATA[15] : MEM_RDATA[7];
          flags_q[`CTAD_FLAG_Z] <= ld_word_q ? (MEM_RDATA == 16'h0000)
                                             : (MEM_RDATA[7:0] == 8'h00);
          flags_q[`CTAD_FLAG_V] <= 1'b0;
          OP_DONE <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Register port read data, valid the cycle after the read strobe
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      if (REG_ADDR[3] == 1'b0)
        REG_RDATA <= gr_q[REG_ADDR[2:0]];
      else if (REG_ADDR == `CTAD_REG_FLAGS)
        REG_RDATA <= {12'h000, flags_q};
      else if (REG_ADDR == `CTAD_REG_STATUS)
        REG_RDATA <= {12'h000, err_q, state_q, state_q != ST_IDLE};
      else
        REG_RDATA <= 16'h0000;
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

endmodule // ctad_datapath

// ### inc/ctad_consts.vh
// Constants for the transfer and arithmetic execution datapath
`ifndef CTAD_CONSTS_VH
`define CTAD_CONSTS_VH
// Operation codes on OP_CODE
`define CTAD_OP_TRANSFER 5'h00
`define CTAD_OP_PULL 5'h01
`define CTAD_OP_STORE_STK 5'h02
`define CTAD_OP_ADD 5'h03
`define CTAD_OP_SUB 5'h04
`define CTAD_OP_SUM_CARRY 5'h05
`define CTAD_OP_MINUS_BORROW 5'h06
`define CTAD_OP_STEP_UP 5'h07
`define CTAD_OP_STEP_DOWN 5'h08
`define CTAD_OP_SMALL_UP 5'h09
`define CTAD_OP_SMALL_DOWN 5'h0a
`define CTAD_OP_FIX_SUM 5'h0b
`define CTAD_OP_FIX_MINUS 5'h0c
`define CTAD_OP_PRODUCT 5'h0d
`define CTAD_OP_QUOTIENT 5'h0e
`define CTAD_OP_COMPARE 5'h0f
`define CTAD_OP_TWOS 5'h10
// Addressing modes on OP_MODE
`define CTAD_AM_REG 3'h0
`define CTAD_AM_IND 3'h1
`define CTAD_AM_DISP 3'h2
`define CTAD_AM_ABS16 3'h3
`define CTAD_AM_IMM 3'h4
`define CTAD_AM_PREDEC 3'h5
`define CTAD_AM_POSTINC 3'h6
`define CTAD_AM_ABS8 3'h7
// Flag register bit positions and reset value
`define CTAD_FLAG_N 3
`define CTAD_FLAG_Z 2
`define CTAD_FLAG_V 1
`define CTAD_FLAG_C 0
`define CTAD_FLAG_RESET 4'h0
// Register port offsets
`define CTAD_REG_GR0 4'h0
`define CTAD_REG_FLAGS 4'h8
`define CTAD_REG_STATUS 4'h9
// Fixed values
`define CTAD_STACK_REG 3'h7
`define CTAD_PAGE_HI 8'hff
`define CTAD_BCD_LO_FIX 8'h06
`define CTAD_BCD_HI_FIX 8'h60
`define CTAD_BCD_MAX 8'h99
`define CTAD_NIBBLE_MAX 4'h9
`endif

// ### testbench/ctad_checker_assertions.sv
// Port-level assertions for the transfer and arithmetic datapath
`timescale 1ns/1ps
`include "ctad_consts.vh"
// ==========================================================
// Checker
module ctad_checker (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire OP_VALID,
  input wire OP_READY,
  input wire [4:0] OP_CODE,
  input wire OP_WORD,
  input wire [2:0] OP_MODE,
  input wire OP_DONE,
  input wire OP_ERR,
  input wire [15:0] MEM_ADDR,
  input wire MEM_WORD,
  input wire MEM_RD,
  input wire MEM_WR
);
  // Accepted request; refusal checks key off this edge
  wire take = OP_VALID && OP_READY;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);

  reset_idle_a: assert property (
    $fell(SYS_RST) |-> OP_READY && !OP_DONE && !MEM_RD && !MEM_WR)
    else $error("outputs not idle after reset");
  err_done_a: assert property (
    OP_ERR |-> OP_DONE && !MEM_RD && !MEM_WR)
    else $error("refusal without done or with memory strobe");
  load_walk_a: assert property (
    MEM_RD |-> !OP_READY ##1 (!MEM_RD && !OP_DONE) ##1 (OP_DONE && OP_READY))
    else $error("load did not finish two cycles after read strobe");
  store_walk_a: assert property (
    MEM_WR |-> !OP_READY ##1 (OP_DONE && !OP_ERR && !MEM_WR))
    else $error("store did not finish one cycle after write strobe");
  mem_excl_a: assert property (
    !(MEM_RD && MEM_WR))
    else $error("read and write strobes together");
  word_even_a: assert property (
    (MEM_RD || MEM_WR) && MEM_WORD |-> !MEM_ADDR[0])
    else $error("word access on odd address");
  stack_word_a: assert property (
    take && (OP_CODE == `CTAD_OP_PULL || OP_CODE == `CTAD_OP_STORE_STK)
    |=> (MEM_RD || MEM_WR) && MEM_WORD)
    else $error("stack access not a word access");
  abs8_word_a: assert property (
    take && OP_CODE == `CTAD_OP_TRANSFER && OP_WORD && OP_MODE == `CTAD_AM_ABS8
    |=> OP_DONE && OP_ERR ##1 !MEM_RD)
    else $error("word short absolute not refused");
  sub_imm_a: assert property (
    take && OP_CODE == `CTAD_OP_SUB && OP_MODE == `CTAD_AM_IMM |=> OP_ERR)
    else $error("subtract immediate not refused");
  word_imm_a: assert property (
    take && OP_WORD && OP_MODE == `CTAD_AM_IMM
    && (OP_CODE == `CTAD_OP_ADD || OP_CODE == `CTAD_OP_COMPARE) |=> OP_ERR)
    else $error("word immediate arithmetic not refused");
  regop_done_a: assert property (
    take && OP_CODE >= `CTAD_OP_ADD |=> OP_DONE && OP_READY)
    else $error("register operation not done next cycle");
endmodule // ctad_checker

bind ctad_datapath ctad_checker i_ctad_checker (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .OP_VALID(OP_VALID), .OP_READY(OP_READY),
  .OP_CODE(OP_CODE), .OP_WORD(OP_WORD), .OP_MODE(OP_MODE), .OP_DONE(OP_DONE),
  .OP_ERR(OP_ERR), .MEM_ADDR(MEM_ADDR), .MEM_WORD(MEM_WORD), .MEM_RD(MEM_RD),
  .MEM_WR(MEM_WR)
);

// ### testbench/ctad_mem_model.sv
// Behavioural memory on the datapath's internal bus
`timescale 1ns/1ps
// ==========================================================
// Memory model
module ctad_mem_model (
  input wire clk,
  input wire [15:0] mem_addr,
  input wire mem_word,
  input wire mem_rd,
  input wire mem_wr,
  input wire [15:0] mem_wdata,
  output logic [15:0] mem_rdata
);
  logic [7:0] mem_q [0:65535];
  logic [15:0] rdata_q = 16'h5a5a;
  wire [15:0] even_a = {mem_addr[15:1], 1'h0};
  wire [15:0] odd_a = {mem_addr[15:1], 1'h1};
  // Data stands only in the cycle after the strobe; otherwise it flips so stale data never matches
  always @(posedge clk) begin
    if (mem_wr && mem_word) begin
      mem_q[even_a] <= mem_wdata[15:8];
      mem_q[odd_a] <= mem_wdata[7:0];
    end else if (mem_wr) begin
      mem_q[mem_addr] <= mem_wdata[7:0];
    end
    if (mem_rd && mem_word) rdata_q <= {mem_q[even_a], mem_q[odd_a]};
    else if (mem_rd) rdata_q <= {~rdata_q[15:8], mem_q[mem_addr]};
    else rdata_q <= ~rdata_q;
  end
  assign mem_rdata = rdata_q;
endmodule // ctad_mem_model

// ### testbench/tb_top.sv
// Self-checking bench for the transfer and arithmetic datapath
`timescale 1ns/1ps
`include "ctad_consts.vh"
// ==========================================================
// Bench top
module tb_top;
  typedef struct {
    logic [4:0] code;
    logic word;
    logic imm;
    logic [15:0] a;
    logic [15:0] b;
    logic [3:0] fin;
    logic [15:0] res;
    logic [3:0] fres;
    logic err;
  } ctad_row_t;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic op_valid = 1'h0, op_word = 1'h0, op_store = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [4:0] op_code = 5'h00;
  logic [2:0] op_mode = 3'h0;
  logic [3:0] op_rd = 4'h0, op_rs = 4'h0, reg_addr = 4'h0;
  logic [15:0] op_imm = 16'h0000, reg_wdata = 16'h0000;
  logic [15:0] mem_rdata, mem_addr, mem_wdata, reg_rdata, rd_val, acc_addr;
  logic op_ready, op_done, op_err, mem_word, mem_rd, mem_wr, last_err;
  int miscompares = 0;
  int cmp_count = 0;
  // Operands a in R1, b in R2 and as immediate; byte ops use the low halves
  ctad_row_t rows [0:22] = '{
    '{5'h03, 1'h0, 1'h0, 16'h0070, 16'h0090, 4'h0, 16'h0000, 4'h5, 1'h0},
    '{5'h03, 1'h0, 1'h1, 16'h0050, 16'h0030, 4'h0, 16'h0080, 4'ha, 1'h0},
    '{5'h03, 1'h1, 1'h0, 16'h7fff, 16'h0001, 4'h0, 16'h8000, 4'ha, 1'h0},
    '{5'h04, 1'h0, 1'h0, 16'h0010, 16'h0020, 4'h0, 16'h00f0, 4'h9, 1'h0},
    '{5'h04, 1'h0, 1'h1, 16'h0010, 16'h0020, 4'h0, 16'h0010, 4'h0, 1'h1},
    '{5'h03, 1'h1, 1'h1, 16'h1234, 16'h0001, 4'h0, 16'h1234, 4'h0, 1'h1},
    '{5'h05, 1'h0, 1'h0, 16'h0001, 16'h0001, 4'h1, 16'h0003, 4'h0, 1'h0},
    '{5'h06, 1'h0, 1'h1, 16'h0005, 16'h0002, 4'h1, 16'h0002, 4'h0, 1'h0},
    '{5'h05, 1'h1, 1'h0, 16'h0001, 16'h0001, 4'h1, 16'h0001, 4'h1, 1'h1},
    '{5'h07, 1'h0, 1'h0, 16'h007f, 16'h0000, 4'h1, 16'h0080, 4'hb, 1'h0},
    '{5'h08, 1'h0, 1'h0, 16'h0000, 16'h0000, 4'h0, 16'h00ff, 4'h8, 1'h0},
    '{5'h09, 1'h1, 1'h0, 16'hffff, 16'h0002, 4'h5, 16'h0001, 4'h5, 1'h0},
    '{5'h0a, 1'h1, 1'h0, 16'h0000, 16'h0000, 4'h0, 16'hffff, 4'h0, 1'h0},
    '{5'h0b, 1'h0, 1'h0, 16'h003c, 16'h0000, 4'h0, 16'h0042, 4'h0, 1'h0},
    '{5'h0b, 1'h0, 1'h0, 16'h00a0, 16'h0000, 4'h0, 16'h0000, 4'h5, 1'h0},
    '{5'h0c, 1'h0, 1'h0, 16'h001f, 16'h0000, 4'h0, 16'h0019, 4'h0, 1'h0},
    '{5'h0d, 1'h0, 1'h0, 16'h00ff, 16'h00ff, 4'h0, 16'hfe01, 4'h0, 1'h0},
    '{5'h0e, 1'h0, 1'h0, 16'h0107, 16'h0010, 4'h0, 16'h0710, 4'h0, 1'h0},
    '{5'h0e, 1'h0, 1'h0, 16'h0107, 16'h0000, 4'h0, 16'h0107, 4'h0, 1'h1},
    '{5'h0f, 1'h0, 1'h1, 16'h0005, 16'h0005, 4'h0, 16'h0005, 4'h4, 1'h0},
    '{5'h0f, 1'h1, 1'h0, 16'h0001, 16'h0002, 4'h0, 16'h0001, 4'h9, 1'h0},
    '{5'h10, 1'h0, 1'h0, 16'h0001, 16'h0000, 4'h0, 16'h00ff, 4'h9, 1'h0},
    '{5'h00, 1'h0, 1'h0, 16'h0000, 16'h0080, 4'h3, 16'h0080, 4'h9, 1'h0}
  };

  always #4 clk = ~clk;
  // Last memory address strobed, paired with its strobe at the same edge
  always @(posedge clk) if (mem_rd || mem_wr) acc_addr <= mem_addr;

  ctad_datapath i_ctad_datapath (
    .CLK_SYS(clk), .SYS_RST(rst), .OP_VALID(op_valid), .OP_READY(op_ready),
    .OP_CODE(op_code), .OP_WORD(op_word), .OP_MODE(op_mode), .OP_STORE(op_store),
    .OP_RD(op_rd), .OP_RS(op_rs), .OP_IMM(op_imm), .OP_DONE(op_done), .OP_ERR(op_err),
    .MEM_ADDR(mem_addr), .MEM_WORD(mem_word), .MEM_RD(mem_rd), .MEM_WR(mem_wr),
    .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata)
  );
  ctad_mem_model i_ctad_mem_model (
    .clk(clk), .mem_addr(mem_addr), .mem_word(mem_word), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
  );

  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 rd_val = reg_rdata;
  endtask
  // Bounded wait: a load is the longest operation at three cycles
  task automatic run_op(input logic [4:0] c, input logic w, input logic [2:0] m,
                        input logic s, input logic [3:0] d, input logic [3:0] r,
                        input logic [15:0] i);
    int n;
    @(posedge clk);
    op_code <= c;
    op_word <= w;
    op_mode <= m;
    op_store <= s;
    op_rd <= d;
    op_rs <= r;
    op_imm <= i;
    op_valid <= 1'h1;
    @(posedge clk);
    op_valid <= 1'h0;
    n = 0;
    #1;
    while (op_done !== 1'h1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 8) begin
      miscompares++;
      $display("mismatch at %0t: operation never finished", $time);
    end
    last_err = op_err;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[k]) begin
      wr_reg(4'h1, rows[k].a);
      wr_reg(4'h2, rows[k].b);
      wr_reg(4'h8, {12'h000, rows[k].fin});
      run_op(rows[k].code, rows[k].word, rows[k].imm ? `CTAD_AM_IMM : `CTAD_AM_REG,
             1'h0, 4'h9, 4'ha, rows[k].b);
      chk({15'h0000, last_err}, {15'h0000, rows[k].err}, "refusal");
      rd_reg(4'h1);
      chk(rd_val, rows[k].res, "result");
      rd_reg(4'h8);
      chk(rd_val, {12'h000, rows[k].fres}, "flags");
    end
    // Stack store and pull always use word size on the stack register
    wr_reg(4'h7, 16'h0200);
    wr_reg(4'h1, 16'hbeef);
    run_op(`CTAD_OP_STORE_STK, 1'h1, `CTAD_AM_PREDEC, 1'h1, 4'h1, 4'h7, 16'h0000);
    chk(acc_addr, 16'h01fe, "stack store address");
    run_op(`CTAD_OP_PULL, 1'h1, `CTAD_AM_POSTINC, 1'h0, 4'h5, 4'h7, 16'h0000);
    rd_reg(4'h5);
    chk(rd_val, 16'hbeef, "pulled word");
    rd_reg(4'h7);
    chk(rd_val, 16'h0200, "stack pointer");
    // Byte store to the top page, then byte post-increment load back
    run_op(`CTAD_OP_TRANSFER, 1'h0, `CTAD_AM_ABS8, 1'h1, 4'h9, 4'h0, 16'h0034);
    chk(acc_addr, 16'hff34, "short absolute page");
    wr_reg(4'h3, 16'hff34);
    run_op(`CTAD_OP_TRANSFER, 1'h0, `CTAD_AM_POSTINC, 1'h0, 4'hc, 4'h3, 16'h0000);
    rd_reg(4'h4);
    chk(rd_val, 16'h00ef, "byte load");
    rd_reg(4'h3);
    chk(rd_val, 16'hff35, "byte step");
    // Odd word addresses fall back to the even word
    run_op(`CTAD_OP_TRANSFER, 1'h1, `CTAD_AM_ABS16, 1'h0, 4'h6, 4'h0, 16'h01ff);
    chk(acc_addr, 16'h01fe, "aligned address");
    wr_reg(4'h6, 16'h0000);
    run_op(`CTAD_OP_TRANSFER, 1'h1, `CTAD_AM_DISP, 1'h0, 4'h6, 4'h7, 16'hffff);
    rd_reg(4'h6);
    chk(rd_val, 16'hbeef, "displacement load");
    // Indirect word load through an odd pointer lands on the even word
    wr_reg(4'h3, 16'h01ff);
    run_op(`CTAD_OP_TRANSFER, 1'h1, `CTAD_AM_IND, 1'h0, 4'h2, 4'h3, 16'h0000);
    rd_reg(4'h2);
    chk(rd_val, 16'hbeef, "indirect load");
    run_op(`CTAD_OP_TRANSFER, 1'h1, `CTAD_AM_ABS8, 1'h0, 4'h6, 4'h0, 16'h0034);
    chk({15'h0000, last_err}, 16'h0001, "word short absolute");
    rd_reg(4'h9);
    chk(rd_val, 16'h0008, "refusal status");
    // Mid-run reset clears registers and flags; unmapped place reads zero
    wr_reg(4'h8, 16'h000f);
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rd_reg(4'h1);
    chk(rd_val, 16'h0000, "register after reset");
    rd_reg(4'h8);
    chk(rd_val, 16'h0000, "flags after reset");
    rd_reg(4'hf);
    chk(rd_val, 16'h0000, "unmapped read");
    conclude();
  end
  // Watchdog: the run needs well under a thousand cycles
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule // tb_top
